// *** src/led_channel_pwm_reset_control.v ***
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "led_pwm_defs.vh"

module led_channel_pwm_reset_control #(
  parameter NCH = 3,
  parameter PWM_W = 8,
  parameter DUR_W = 16
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst,
  // AXI4-Lite write
  input  wire [7:0]              s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]              s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  // Sink outputs
  output reg                     sink_out_a,
  output reg                     sink_out_b,
  output reg                     sink_out_c,
  output reg  [3:0]              sink_ma_a,
  output reg  [3:0]              sink_ma_b,
  output reg  [3:0]              sink_ma_c,
  // Open-drain interrupt and summary
  output reg                     irq_out_n_oe,
  output reg                     irq,
  output reg                     standby
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg  [7:0]             global_control_reg_q;
  reg  [4:0]             channel_config_reg_q [0:NCH-1];
  reg  [PWM_W-1:0]       channel_brightness_regs_q [0:NCH-1];
  reg  [DUR_W-1:0]       eng_dur_q [0:NCH-1];
  reg  [DUR_W-1:0]       eng_cnt_q [0:NCH-1];
  reg  [PWM_W-1:0]       eng_lvl_q [0:NCH-1];
  reg  [NCH-1:0]         eng_run_q;
  reg  [NCH-1:0]         irq_status_q;
  reg  [NCH-1:0]         irq_mask_q;
  reg  [PWM_W-1:0]       pwm_cnt_q;
  reg                    soft_rst_q;
  reg  [7:0]             aw_addr_q;
  reg  [31:0]            w_data_q;
  reg  [3:0]             w_strb_q;
  reg                    aw_have_q;
  reg                    w_have_q;

  wire                   chip_en  = global_control_reg_q[`GC_CHIP_EN];
  wire [2:0]             irq_en   = global_control_reg_q[`GC_IRQ_EN_LO+2:`GC_IRQ_EN_LO];
  wire                   clr      = rst | soft_rst_q;
  wire                   wr_go    = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire                   wr_b0    = wr_go & w_strb_q[0];
  wire [NCH-1:0]         eng_done;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel capture
  always @(posedge clk) begin
    if (clr) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      soft_rst_q    <= 1'b0;
    end else begin
      // Each ready pulses one cycle per accepted item
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q > `OFF_IRQ_MASK || aw_addr_q[1:0] != 2'b00) ?
                        `RESP_SLVERR : `RESP_OKAY;
        // Soft reset fires after response is queued
        soft_rst_q   <= wr_b0 && aw_addr_q == `OFF_SOFT_RESET &&
                        w_data_q[7:0] == `SOFT_RESET_CODE;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global registers and interrupt status
  always @(posedge clk) begin
    if (clr) begin
      global_control_reg_q <= `GC_RESET;
      irq_mask_q           <= {NCH{1'b0}};
      irq_status_q         <= {NCH{1'b0}};
    end else begin
      // Byte lane zero carries every control field
      if (wr_b0 && aw_addr_q == `OFF_GLOBAL_CTRL)
        global_control_reg_q <= w_data_q[7:0];
      if (wr_b0 && aw_addr_q == `OFF_IRQ_MASK)
        irq_mask_q <= w_data_q[NCH-1:0];
      // Set wins over write-one-to-clear
      irq_status_q <= (irq_status_q & ~((wr_b0 && aw_addr_q == `OFF_IRQ_STATUS) ?
                      w_data_q[NCH-1:0] : {NCH{1'b0}})) | eng_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared PWM period counter
  always @(posedge clk) begin
    if (clr)
      pwm_cnt_q <= {PWM_W{1'b0}};
    // Counts 0 to max-1 so full scale stays on all period
    else if (chip_en)
      pwm_cnt_q <= (pwm_cnt_q == {PWM_W{1'b1}} - 1'b1) ? {PWM_W{1'b0}} : pwm_cnt_q + 1'b1;
    else
      pwm_cnt_q <= {PWM_W{1'b0}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel config and per-engine sequencer
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gen_ch
      // Register offsets of this channel and its engine
      localparam integer CFG_AT = `OFF_CFG_A + `REG_STRIDE * g;
      localparam integer BRT_AT = `OFF_BRIGHT_A + `REG_STRIDE * g;
      localparam integer DUR_AT = `OFF_ENG_DUR_0 + `REG_STRIDE * g;
      wire [7:0] off_cfg = CFG_AT[7:0];
      wire [7:0] off_brt = BRT_AT[7:0];
      wire [7:0] off_dur = DUR_AT[7:0];
      wire       used;
      wire       step;
      // Engine steps once per PWM period while enabled
      assign used = chip_en && eng_dur_q[g] != {DUR_W{1'b0}};
      assign step = used && eng_run_q[g] && pwm_cnt_q == {PWM_W{1'b0}};
      // Completion event only on the final ramp step
      assign eng_done[g] = step && eng_cnt_q[g] == eng_dur_q[g] - 1'b1 &&
                           irq_en[g];

      // Host-written channel registers
      always @(posedge clk) begin
        if (clr) begin
          channel_config_reg_q[g]      <= `CFG_RESET;
          channel_brightness_regs_q[g] <= {PWM_W{1'b0}};
          eng_dur_q[g]                 <= {DUR_W{1'b0}};
        end else begin
          if (wr_b0 && aw_addr_q == off_cfg)
            channel_config_reg_q[g] <= w_data_q[4:0];
          if (wr_b0 && aw_addr_q == off_brt)
            channel_brightness_regs_q[g] <= w_data_q[PWM_W-1:0];
          if (wr_go && aw_addr_q == off_dur)
            eng_dur_q[g] <= w_data_q[DUR_W-1:0];
        end
      end

      // Engine: ramps level once per PWM period over its duration
      always @(posedge clk) begin
        if (clr) begin
          eng_run_q[g] <= 1'b0;
          eng_cnt_q[g] <= {DUR_W{1'b0}};
          eng_lvl_q[g] <= {PWM_W{1'b0}};
        end else if (wr_go && aw_addr_q == off_dur) begin
          eng_run_q[g] <= 1'b1;
          eng_cnt_q[g] <= {DUR_W{1'b0}};
          eng_lvl_q[g] <= {PWM_W{1'b0}};
        end else if (step) begin
          eng_lvl_q[g] <= eng_lvl_q[g] + 1'b1;
          if (eng_cnt_q[g] == eng_dur_q[g] - 1'b1)
            eng_run_q[g] <= 1'b0;
          else
            eng_cnt_q[g] <= eng_cnt_q[g] + 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: source select, compare, current level
  reg [PWM_W-1:0] duty_a, duty_b, duty_c;
  always @* begin
    // Engine mode takes the mapped engine level, else the host value
    duty_a = channel_config_reg_q[0][`CFG_MODE] ?
             eng_lvl_q[channel_config_reg_q[0][`CFG_ENG_LO+1:`CFG_ENG_LO] % NCH] :
             channel_brightness_regs_q[0];
    duty_b = channel_config_reg_q[1][`CFG_MODE] ?
             eng_lvl_q[channel_config_reg_q[1][`CFG_ENG_LO+1:`CFG_ENG_LO] % NCH] :
             channel_brightness_regs_q[1];
    duty_c = channel_config_reg_q[2][`CFG_MODE] ?
             eng_lvl_q[channel_config_reg_q[2][`CFG_ENG_LO+1:`CFG_ENG_LO] % NCH] :
             channel_brightness_regs_q[2];
  end

  always @(posedge clk) begin
    if (clr) begin
      sink_out_a   <= 1'b0;
      sink_out_b   <= 1'b0;
      sink_out_c   <= 1'b0;
      sink_ma_a    <= 4'h0;
      sink_ma_b    <= 4'h0;
      sink_ma_c    <= 4'h0;
      irq          <= 1'b0;
      irq_out_n_oe <= 1'b0;
      standby      <= 1'b1;
    end else begin
      // Full scale stays on all period, zero never on
      sink_out_a   <= chip_en && duty_a > pwm_cnt_q;
      sink_out_b   <= chip_en && duty_b > pwm_cnt_q;
      sink_out_c   <= chip_en && duty_c > pwm_cnt_q;
      // Current code scaled to milliamps, zero in standby
      sink_ma_a    <= chip_en ? channel_config_reg_q[0][1:0] * 4'd`CUR_STEP_MA : 4'h0;
      sink_ma_b    <= chip_en ? channel_config_reg_q[1][1:0] * 4'd`CUR_STEP_MA : 4'h0;
      sink_ma_c    <= chip_en ? channel_config_reg_q[2][1:0] * 4'd`CUR_STEP_MA : 4'h0;
      // Interrupt level and its open-drain pin move together
      irq          <= |(irq_status_q & irq_mask_q);
      irq_out_n_oe <= |(irq_status_q & irq_mask_q);
      standby      <= ~chip_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  always @(posedge clk) begin
    if (clr) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr)
          `OFF_GLOBAL_CTRL: s_axi_rdata[7:0] <= global_control_reg_q;
          // Soft reset register is write-only
          `OFF_SOFT_RESET:  s_axi_rdata      <= 32'h0000_0000;
          `OFF_CFG_A:       s_axi_rdata[4:0] <= channel_config_reg_q[0];
          `OFF_CFG_B:       s_axi_rdata[4:0] <= channel_config_reg_q[1];
          `OFF_CFG_C:       s_axi_rdata[4:0] <= channel_config_reg_q[2];
          `OFF_BRIGHT_A:    s_axi_rdata[PWM_W-1:0] <= channel_brightness_regs_q[0];
          `OFF_BRIGHT_B:    s_axi_rdata[PWM_W-1:0] <= channel_brightness_regs_q[1];
          `OFF_BRIGHT_C:    s_axi_rdata[PWM_W-1:0] <= channel_brightness_regs_q[2];
          `OFF_ENG_DUR_0:   s_axi_rdata[DUR_W-1:0] <= eng_dur_q[0];
          `OFF_ENG_DUR_1:   s_axi_rdata[DUR_W-1:0] <= eng_dur_q[1];
          `OFF_ENG_DUR_2:   s_axi_rdata[DUR_W-1:0] <= eng_dur_q[2];
          `OFF_IRQ_STATUS:  s_axi_rdata[NCH-1:0] <= irq_status_q;
          `OFF_IRQ_MASK:    s_axi_rdata[NCH-1:0] <= irq_mask_q;
          `OFF_STATUS:      s_axi_rdata[NCH:0]   <= {~chip_en, eng_run_q};
          // Unmapped or misaligned offsets answer with an error
          default:          s_axi_rresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // led_channel_pwm_reset_control
`default_nettype wire

// *** src/led_pwm_defs.vh ***
`ifndef LED_PWM_DEFS_VH
`define LED_PWM_DEFS_VH

// Register byte offsets
`define OFF_GLOBAL_CTRL   8'h00
`define OFF_SOFT_RESET    8'h04
`define OFF_CFG_A         8'h08
`define OFF_CFG_B         8'h0C
`define OFF_CFG_C         8'h10
`define OFF_BRIGHT_A      8'h14
`define OFF_BRIGHT_B      8'h18
`define OFF_BRIGHT_C      8'h1C
`define OFF_ENG_DUR_0     8'h20
`define OFF_ENG_DUR_1     8'h24
`define OFF_ENG_DUR_2     8'h28
`define OFF_IRQ_STATUS    8'h2C
`define OFF_IRQ_MASK      8'h30
`define OFF_STATUS        8'h34

// Spacing of per-channel registers
`define REG_STRIDE        8'h04

// Soft reset code
`define SOFT_RESET_CODE   8'h55

// Global control fields
`define GC_CHIP_EN        0
`define GC_PWR_UP_IND     1
`define GC_IRQ_EN_LO      5
`define GC_RESET          8'h02

// Channel config fields: [1:0] current level, [2] engine mode, [4:3] engine select
`define CFG_CUR_LO        0
`define CFG_MODE          2
`define CFG_ENG_LO        3
`define CFG_RESET         5'h00

// Current step per code in mA
`define CUR_STEP_MA       5

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// *** sim/led_ctl_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module led_ctl_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Sink and interrupt outputs
  input wire logic [3:0] sink_ma_a,
  input wire logic [3:0] sink_ma_b,
  input wire logic [3:0] sink_ma_c,
  input wire logic       irq_out_n_oe,
  input wire logic       irq,
  input wire logic       standby
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bus handshake timing
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held too long");
  AST_W_PULSE: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held too long");
  AST_AW_CAUSE: assert property (s_axi_awready |-> $past(s_axi_awvalid))
    else $error("awready without request");
  AST_AR_TO_R: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // Output relations
  AST_IRQ_PIN: assert property (irq == irq_out_n_oe)
    else $error("pin and irq differ");
  AST_MA_CODES: assert property ((sink_ma_a inside {4'h0, 4'h5, 4'ha, 4'hf})
    && (sink_ma_b inside {4'h0, 4'h5, 4'ha, 4'hf}) && (sink_ma_c inside {4'h0, 4'h5, 4'ha, 4'hf}))
    else $error("sink current off grid");
  AST_STANDBY_MA: assert property (standby |-> sink_ma_a == 4'h0 && sink_ma_b == 4'h0)
    else $error("current in standby");
  AST_RST_VALUES: assert property ($fell(rst) |-> standby && !irq && sink_ma_c == 4'h0)
    else $error("outputs wrong after reset");
endmodule // led_ctl_chk
bind led_channel_pwm_reset_control led_ctl_chk led_ctl_chk_i (.clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wready, .s_axi_arready, .s_axi_rvalid, .sink_ma_a, .sink_ma_b,
  .sink_ma_c, .irq_out_n_oe, .irq, .standby);
`default_nettype wire

// *** sim/led_pin_load.sv ***
`timescale 1ns/1ns
`default_nettype none
module led_pin_load (
  // Clock
  input wire logic  clk,
  // Pins of the block
  input wire logic  sink_out_a,
  input wire logic  sink_out_b,
  input wire logic  sink_out_c,
  input wire logic  irq_out_n_oe,
  // Measurement control
  input wire logic  clr,
  // Observed levels
  output wire logic irq_out_n,
  output var int    high_cnt,
  output var int    high_cnt_b,
  output var int    high_cnt_c
);
  // Open-drain line pulled up when released
  assign irq_out_n = irq_out_n_oe ? 1'b0 : 1'b1;
  // Count cycles each sink conducts
  always @(posedge clk) begin
    high_cnt   <= clr ? 0 : high_cnt + int'(sink_out_a);
    high_cnt_b <= clr ? 0 : high_cnt_b + int'(sink_out_b);
    high_cnt_c <= clr ? 0 : high_cnt_c + int'(sink_out_c);
  end
endmodule // led_pin_load
`default_nettype wire

// *** sim/tb_led_channel_pwm_reset_control.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "led_pwm_defs.vh"
module tb_led_channel_pwm_reset_control;
  logic        clk = 0, rst = 1, clr = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire  [31:0] s_axi_rdata;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         sink_out_a, sink_out_b, sink_out_c, irq_out_n_oe, irq, standby, irq_out_n;
  wire  [3:0]  sink_ma_a, sink_ma_b, sink_ma_c;
  int          n_errors = 0, n_compared = 0, cnt, cnt_b, cnt_c, n;
  // Clock
  always #2 clk = ~clk;
  led_channel_pwm_reset_control led_channel_pwm_reset_control_i (.clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sink_out_a, .sink_out_b,
    .sink_out_c, .sink_ma_a, .sink_ma_b, .sink_ma_c, .irq_out_n_oe, .irq, .standby);
  led_pin_load led_pin_load_i (.clk, .sink_out_a, .sink_out_b, .sink_out_c, .irq_out_n_oe,
    .clr, .irq_out_n, .high_cnt(cnt), .high_cnt_b(cnt_b), .high_cnt_c(cnt_c));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and checks
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(input bit late);
    if (late) begin
      n_errors++;
      $display("ERROR %0t: no answer", $time);
      report_and_stop;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bus master tasks
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er, input [3:0] st = 4'hf);
    @(posedge clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 64);
    s_axi_bready <= 1'b0;
    guard(n >= 64);
    cmp(s_axi_bresp, er);
  endtask
  task automatic rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    @(posedge clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 64);
    s_axi_rready <= 1'b0;
    guard(n >= 64);
    cmp(s_axi_rresp, er);
    if (er == `RESP_OKAY) cmp(s_axi_rdata, exp);
  endtask
  // Sink on-time counted over 255 cycles, exactly one 255-cycle modulation period
  task automatic measure;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (256) @(posedge clk);
  endtask
  task automatic pwm(input [7:0] v);
    wr(`OFF_BRIGHT_A, v, `RESP_OKAY);
    rd(`OFF_BRIGHT_A, v, `RESP_OKAY);
    measure;
    cmp(cnt, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`OFF_GLOBAL_CTRL, 32'h0000_0002, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h0000_0008, `RESP_OKAY);
    wr(`OFF_GLOBAL_CTRL, 32'h0000_0001, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h0000_0000, `RESP_OKAY);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_CFG_A, i, `RESP_OKAY);
      @(posedge clk);
      cmp(sink_ma_a, 5 * i);
    end
    pwm(8'h00);
    pwm(8'h80);
    pwm(8'hff);
    $display("test current and duty done");
    wr(`OFF_CFG_B, 32'h0000_000d, `RESP_OKAY);
    wr(`OFF_CFG_C, 32'h0000_000e, `RESP_OKAY);
    wr(`OFF_IRQ_MASK, 32'h0000_0002, `RESP_OKAY);
    wr(`OFF_GLOBAL_CTRL, 32'h0000_0041, `RESP_OKAY);
    wr(`OFF_ENG_DUR_1, 32'h0000_0001, `RESP_OKAY);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    guard(n >= 2000);
    cmp(irq_out_n, 1'b0);
    rd(`OFF_IRQ_STATUS, 32'h0000_0002, `RESP_OKAY);
    measure;
    cmp(cnt_b, 1);
    cmp(cnt_c, 1);
    cmp(sink_ma_b, 5);
    cmp(sink_ma_c, 10);
    wr(`OFF_IRQ_MASK, 32'h0000_0000, `RESP_OKAY);
    @(posedge clk);
    cmp(irq, 1'b0);
    wr(`OFF_IRQ_STATUS, 32'h0000_0002, `RESP_OKAY);
    rd(`OFF_IRQ_STATUS, 32'h0000_0000, `RESP_OKAY);
    wr(`OFF_IRQ_MASK, 32'h0000_0002, `RESP_OKAY);
    @(posedge clk);
    cmp(irq, 1'b0);
    $display("test engine interrupt done");
    wr(8'h38, 32'h0000_0000, `RESP_SLVERR);
    rd(8'h3c, 32'h0000_0000, `RESP_SLVERR);
    wr(`OFF_SOFT_RESET, 32'h0000_0055, `RESP_OKAY, 4'he);
    rd(`OFF_GLOBAL_CTRL, 32'h0000_0041, `RESP_OKAY);
    wr(`OFF_SOFT_RESET, 32'h0000_0055, `RESP_OKAY);
    rd(`OFF_GLOBAL_CTRL, 32'h0000_0002, `RESP_OKAY);
    rd(`OFF_CFG_A, 32'h0000_0000, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h0000_0008, `RESP_OKAY);
    cmp(sink_ma_a, 4'h0);
    wr(`OFF_GLOBAL_CTRL, 32'h0000_0001, `RESP_OKAY);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`OFF_GLOBAL_CTRL, 32'h0000_0002, `RESP_OKAY);
    cmp(standby, 1'b1);
    $display("test resets done");
    report_and_stop;
  end
endmodule // tb_led_channel_pwm_reset_control
`default_nettype wire
